/* logic/misc_status_ctrl.sv */
// Top: control and status register bank with Wishbone slave
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module misc_status_ctrl #(
  parameter int gpio_count = 7
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone classic slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  // Strap pins
  input  wire logic [2:0]            index_strap_i,
  input  wire logic [2:0]            mode_strap_i,
  // Forward link fault inputs, same clock
  input  wire logic                  lock_detect_i,
  input  wire logic                  parity_error_i,
  input  wire logic                  clock_error_i,
  input  wire logic                  control_error_i,
  input  wire logic                  filter_wait_i,
  // Raw mode framing
  input  wire logic                  raw_mode_i,
  input  wire logic                  frame_active_strobe_i,
  // GPIO
  input  wire logic [gpio_count-1:0] gpio_output_mode_i,
  output logic [gpio_count-1:0]      pulldown_enable_o,
  // Status and control outputs
  output logic                       receiver_lock_o,
  output logic                       frame_start_o,
  output logic                       encoder_check_enable_o,
  output logic                       irq_o
);
  import misc_status_pkg::*;

  // --------------------------------------------------------------
  // Strap capture
  // --------------------------------------------------------------
  // Straps are pins: two flops before anything reads them
  logic [5:0] strap_meta;
  logic [5:0] strap_sync;
  logic [5:0] next_strap_meta;
  logic [5:0] next_strap_sync;
  logic [2:0] index_strap_value;
  logic [2:0] mode_strap_value;
  logic [2:0] next_index_strap_value;
  logic [2:0] next_mode_strap_value;
  logic       index_strap_decoded;
  logic       mode_strap_decoded;
  logic       next_index_strap_decoded;
  logic       next_mode_strap_decoded;
  logic [7:0] settle_count;
  logic [7:0] next_settle_count;
  logic       strap_done_event;

  always_comb begin
    next_strap_meta          = {index_strap_i, mode_strap_i};
    next_strap_sync          = strap_meta;
    next_settle_count        = settle_count;
    next_index_strap_value   = index_strap_value;
    next_mode_strap_value    = mode_strap_value;
    next_index_strap_decoded = index_strap_decoded;
    next_mode_strap_decoded  = mode_strap_decoded;
    strap_done_event         = 1'b0;
    if (settle_count != 8'(strap_settle_cycles)) begin
      next_settle_count = settle_count + 8'h01;
    end else if (!index_strap_decoded) begin
      next_index_strap_value   = strap_sync[5:3];
      next_mode_strap_value    = strap_sync[2:0];
      next_index_strap_decoded = 1'b1;
      next_mode_strap_decoded  = 1'b1;
      strap_done_event         = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_meta          <= 6'h00;
      strap_sync          <= 6'h00;
      settle_count        <= 8'h00;
      index_strap_value   <= 3'h0;
      mode_strap_value    <= 3'h0;
      index_strap_decoded <= 1'b0;
      mode_strap_decoded  <= 1'b0;
    end else begin
      strap_meta          <= next_strap_meta;
      strap_sync          <= next_strap_sync;
      settle_count        <= next_settle_count;
      index_strap_value   <= next_index_strap_value;
      mode_strap_value    <= next_mode_strap_value;
      index_strap_decoded <= next_index_strap_decoded;
      mode_strap_decoded  <= next_mode_strap_decoded;
    end
  end

  // --------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------
  logic [7:0]            link_error_monitor_ctrl;
  logic [7:0]            encoder_integrity_ctrl;
  logic [7:0]            spare_reg_bb;
  logic [7:0]            frame_active_minimum;
  logic [7:0]            spare_reg_bd;
  logic [gpio_count-1:0] pin_pulldown_disable;
  logic [irq_width-1:0]  irq_status;
  logic [irq_width-1:0]  irq_enable;
  logic [7:0]            next_link_error_monitor_ctrl;
  logic [7:0]            next_encoder_integrity_ctrl;
  logic [7:0]            next_spare_reg_bb;
  logic [7:0]            next_frame_active_minimum;
  logic [7:0]            next_spare_reg_bd;
  logic [gpio_count-1:0] next_pin_pulldown_disable;
  logic [irq_width-1:0]  next_irq_status;
  logic [irq_width-1:0]  next_irq_enable;
  logic                  next_ack;
  logic [31:0]           next_dat;
  logic                  bus_req;
  logic                  wr_lane0;
  logic [irq_width-1:0]  irq_events;
  logic                  frame_start_event;

  link_monitor_if mon_if ();

  assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];

  always_comb begin
    next_link_error_monitor_ctrl = link_error_monitor_ctrl;
    next_encoder_integrity_ctrl  = encoder_integrity_ctrl;
    next_spare_reg_bb            = spare_reg_bb;
    next_frame_active_minimum    = frame_active_minimum;
    next_spare_reg_bd            = spare_reg_bd;
    next_pin_pulldown_disable    = pin_pulldown_disable;
    next_irq_enable              = irq_enable;
    next_irq_status              = irq_status;
    next_ack                     = bus_req;
    next_dat                     = 32'h0000_0000;
    if (wr_lane0) begin
      case (wb_adr_i)
        // Reserved top bits read as zero
        link_error_monitor_ctrl_off: next_link_error_monitor_ctrl = {2'b00, wb_dat_i[5:0]};
        encoder_integrity_ctrl_off:  next_encoder_integrity_ctrl = wb_dat_i[7:0];
        spare_reg_bb_off:            next_spare_reg_bb = wb_dat_i[7:0];
        frame_active_minimum_off:    next_frame_active_minimum = wb_dat_i[7:0];
        spare_reg_bd_off:            next_spare_reg_bd = wb_dat_i[7:0];
        gpio_pulldown_ctrl_off:      next_pin_pulldown_disable = wb_dat_i[gpio_count-1:0];
        irq_enable_off:              next_irq_enable = wb_dat_i[irq_width-1:0];
        irq_clear_off:               next_irq_status = irq_status & ~wb_dat_i[irq_width-1:0];
        default:                     next_dat = 32'h0000_0000;
      endcase
    end
    // Set wins over a clear in the same cycle
    next_irq_status = next_irq_status | irq_events;
    if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        strap_decode_status_off:
          next_dat[7:0] = {index_strap_decoded, index_strap_value, mode_strap_decoded, mode_strap_value};
        link_error_monitor_ctrl_off: next_dat[7:0] = link_error_monitor_ctrl;
        encoder_integrity_ctrl_off:  next_dat[7:0] = encoder_integrity_ctrl;
        spare_reg_bb_off:            next_dat[7:0] = spare_reg_bb;
        frame_active_minimum_off:    next_dat[7:0] = frame_active_minimum;
        spare_reg_bd_off:            next_dat[7:0] = spare_reg_bd;
        gpio_pulldown_ctrl_off:      next_dat[gpio_count-1:0] = pin_pulldown_disable;
        irq_status_off:              next_dat[irq_width-1:0] = irq_status;
        irq_enable_off:              next_dat[irq_width-1:0] = irq_enable;
        default:                     next_dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_error_monitor_ctrl <= link_error_monitor_reset;
      encoder_integrity_ctrl  <= encoder_integrity_reset;
      spare_reg_bb            <= spare_bb_reset;
      frame_active_minimum    <= frame_active_min_reset;
      spare_reg_bd            <= spare_bd_reset;
      pin_pulldown_disable    <= gpio_count'(pulldown_disable_reset);
      irq_status              <= '0;
      irq_enable              <= '0;
      wb_ack_o                <= 1'b0;
      wb_dat_o                <= 32'h0000_0000;
    end else begin
      link_error_monitor_ctrl <= next_link_error_monitor_ctrl;
      encoder_integrity_ctrl  <= next_encoder_integrity_ctrl;
      spare_reg_bb            <= next_spare_reg_bb;
      frame_active_minimum    <= next_frame_active_minimum;
      spare_reg_bd            <= next_spare_reg_bd;
      pin_pulldown_disable    <= next_pin_pulldown_disable;
      irq_status              <= next_irq_status;
      irq_enable              <= next_irq_enable;
      wb_ack_o                <= next_ack;
      wb_dat_o                <= next_dat;
    end
  end

  // --------------------------------------------------------------
  // Link error monitor
  // --------------------------------------------------------------
  assign mon_if.ignore_filter_wait = link_error_monitor_ctrl[sfil_wait_bit];
  assign mon_if.count_enable       = link_error_monitor_ctrl[count_en_bit];
  assign mon_if.threshold          = link_error_monitor_ctrl[3:0];

  link_error_monitor link_error_monitor_inst (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .lock_detect_i   (lock_detect_i),
    .parity_error_i  (parity_error_i),
    .clock_error_i   (clock_error_i),
    .control_error_i (control_error_i),
    .filter_wait_i   (filter_wait_i),
    .mon             (mon_if.monitor)
  );

  // --------------------------------------------------------------
  // Raw mode frame start
  // --------------------------------------------------------------
  logic [7:0] active_count;
  logic [7:0] next_active_count;
  logic       frame_started;
  logic       next_frame_started;

  always_comb begin
    next_active_count  = active_count;
    next_frame_started = frame_started;
    frame_start_event  = 1'b0;
    if (!raw_mode_i || !frame_active_strobe_i) begin
      next_active_count  = 8'h00;
      next_frame_started = 1'b0;
    end else if (!frame_started) begin
      if (active_count + 8'h01 >= frame_active_minimum) begin
        next_frame_started = 1'b1;
        frame_start_event  = 1'b1;
      end else begin
        next_active_count = active_count + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_count  <= 8'h00;
      frame_started <= 1'b0;
      frame_start_o <= 1'b0;
    end else begin
      active_count  <= next_active_count;
      frame_started <= next_frame_started;
      frame_start_o <= frame_start_event;
    end
  end

  // --------------------------------------------------------------
  // Outputs and interrupts
  // --------------------------------------------------------------
  assign irq_events = {strap_done_event, frame_start_event, mon_if.lock_gained, mon_if.lock_lost};
  assign irq_o      = |(irq_status & irq_enable);

  assign receiver_lock_o        = mon_if.lock;
  assign encoder_check_enable_o = ~encoder_integrity_ctrl[crc_dis_bit];
  assign pulldown_enable_o      = ~gpio_output_mode_i & ~pin_pulldown_disable;

endmodule : misc_status_ctrl
`default_nettype wire

/* logic/misc_status_pkg.sv */
// Package: register map, field layout, reset values and counts of the status/control bank
// Functional notes
// - Index-done flag, bit 7, sets once index strap value is latched.
// - Decoded index strap value reads in bits 6:4.
// - Mode-done flag, bit 3, sets once mode strap value is latched.
// - Decoded mode strap value reads in bits 2:0.
// - Filter-wait ignore bit, default one, masks errors after filter updates.
// - Error-count enable bit, default one, enables link error counting.
// - Counting enabled: lock drops when counter reaches 4-bit threshold, default three.
// - Encoder control bit 7 disables CRC check when one, resets one.
// - Raw mode: frame start only after frame-active held programmed count.
// - Pull-down enabled automatically when GPIO is not an output.
// - Seven disable bits turn off pull-downs, even input-only; reset zero.
package misc_status_pkg;

  localparam logic [7:0] strap_decode_status_off     = 8'hb8;
  localparam logic [7:0] link_error_monitor_ctrl_off = 8'hb9;
  localparam logic [7:0] encoder_integrity_ctrl_off  = 8'hba;
  localparam logic [7:0] spare_reg_bb_off            = 8'hbb;
  localparam logic [7:0] frame_active_minimum_off    = 8'hbc;
  localparam logic [7:0] spare_reg_bd_off            = 8'hbd;
  localparam logic [7:0] gpio_pulldown_ctrl_off      = 8'hbe;
  localparam logic [7:0] irq_status_off              = 8'hc0;
  localparam logic [7:0] irq_enable_off              = 8'hc1;
  localparam logic [7:0] irq_clear_off               = 8'hc2;

  localparam int index_done_bit  = 7;
  localparam int index_lsb       = 4;
  localparam int mode_done_bit   = 3;
  localparam int mode_lsb        = 0;
  localparam int sfil_wait_bit   = 5;
  localparam int count_en_bit    = 4;
  localparam int crc_dis_bit     = 7;

  localparam logic [7:0] link_error_monitor_reset = 8'h0033;
  localparam logic [7:0] encoder_integrity_reset  = 8'h0083;
  localparam logic [7:0] spare_bb_reset           = 8'h0074;
  localparam logic [7:0] frame_active_min_reset   = 8'h0080;
  localparam logic [7:0] spare_bd_reset           = 8'h0000;
  localparam logic [6:0] pulldown_disable_reset   = 7'h00;

  // Interrupt status bit positions
  localparam int irq_lock_lost_bit  = 0;
  localparam int irq_lock_gain_bit  = 1;
  localparam int irq_frame_start_bit = 2;
  localparam int irq_strap_done_bit = 3;
  localparam int irq_width          = 4;

  // Strap decode settle time after reset release
  localparam int strap_settle_ns     = 40;
  localparam int clk_period_ns       = 4;
  localparam int strap_settle_cycles = (strap_settle_ns + clk_period_ns - 1) / clk_period_ns;

endpackage : misc_status_pkg

/* logic/link_monitor_if.sv */
// Interface: control and status between register bank and link error monitor
`timescale 1ns/10ps
`default_nettype none
interface link_monitor_if;
  logic       ignore_filter_wait;
  logic       count_enable;
  logic [3:0] threshold;
  logic       lock;
  logic [3:0] error_count;
  logic       lock_lost;
  logic       lock_gained;

  modport bank (
    output ignore_filter_wait,
    output count_enable,
    output threshold,
    input  lock,
    input  error_count,
    input  lock_lost,
    input  lock_gained
  );

  modport monitor (
    input  ignore_filter_wait,
    input  count_enable,
    input  threshold,
    output lock,
    output error_count,
    output lock_lost,
    output lock_gained
  );
endinterface : link_monitor_if
`default_nettype wire

/* logic/link_error_monitor.sv */
// Forward-link error counter and lock-drop decision
`timescale 1ns/10ps
`default_nettype none
module link_error_monitor (
  input  wire logic    clk_i,
  input  wire logic    rst_i,
  input  wire logic    lock_detect_i,
  input  wire logic    parity_error_i,
  input  wire logic    clock_error_i,
  input  wire logic    control_error_i,
  input  wire logic    filter_wait_i,
  link_monitor_if.monitor mon
);
  import misc_status_pkg::*;

  logic       lock;
  logic       next_lock;
  logic [3:0] count;
  logic [3:0] next_count;
  logic       error_seen;
  logic [3:0] count_inc;

  // --------------------------------------------------------------
  // Error qualification and counting
  // --------------------------------------------------------------
  always_comb begin
    error_seen = parity_error_i | clock_error_i | control_error_i;
    if (filter_wait_i && mon.ignore_filter_wait) begin
      error_seen = 1'b0;
    end
    count_inc  = count + 4'h1;
    next_lock  = lock;
    next_count = count;
    if (!lock) begin
      if (lock_detect_i) begin
        next_lock  = 1'b1;
        next_count = 4'h0;
      end
    end else if (!lock_detect_i) begin
      next_lock = 1'b0;
    end else if (error_seen) begin
      if (mon.count_enable) begin
        next_count = count_inc;
        if (count_inc >= mon.threshold) begin
          next_lock = 1'b0;
        end
      end else begin
        next_lock = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock  <= 1'b0;
      count <= 4'h0;
    end else begin
      lock  <= next_lock;
      count <= next_count;
    end
  end

  assign mon.lock        = lock;
  assign mon.error_count = count;
  assign mon.lock_lost   = lock & ~next_lock;
  assign mon.lock_gained = ~lock & next_lock;

endmodule : link_error_monitor
`default_nettype wire

/* verif/misc_status_ctrl_checker.sv */
// Checker: port-level assertions for the status and control bank
`timescale 1ns/10ps
`default_nettype none
module misc_status_ctrl_checker #(
  parameter int gpio_count = 7
) (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic [7:0]            wb_adr_i,
  input wire logic [3:0]            wb_sel_i,
  input wire logic [31:0]           wb_dat_i,
  input wire logic [31:0]           wb_dat_o,
  input wire logic                  wb_ack_o,
  input wire logic [2:0]            index_strap_i,
  input wire logic [2:0]            mode_strap_i,
  input wire logic                  lock_detect_i,
  input wire logic                  parity_error_i,
  input wire logic                  clock_error_i,
  input wire logic                  control_error_i,
  input wire logic                  filter_wait_i,
  input wire logic                  raw_mode_i,
  input wire logic                  frame_active_strobe_i,
  input wire logic [gpio_count-1:0] gpio_output_mode_i,
  input wire logic [gpio_count-1:0] pulldown_enable_o,
  input wire logic                  receiver_lock_o,
  input wire logic                  frame_start_o,
  input wire logic                  encoder_check_enable_o,
  input wire logic                  irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_pulldown_outputs: assert property ((pulldown_enable_o & gpio_output_mode_i) == '0)
    else $error("pull-down enabled on an output pin");
  a_lock_acquire: assert property (!receiver_lock_o && lock_detect_i |=> receiver_lock_o)
    else $error("lock not acquired");
  a_lock_loss_detect: assert property (receiver_lock_o && !lock_detect_i |=> !receiver_lock_o)
    else $error("lock kept without detect");
  a_lock_hold_clean: assert property (receiver_lock_o && lock_detect_i
    && !(parity_error_i || clock_error_i || control_error_i) |=> receiver_lock_o)
    else $error("lock dropped without an error");
  a_frame_single: assert property (frame_start_o |=> !frame_start_o)
    else $error("frame start longer than one cycle");
  a_frame_cause: assert property (frame_start_o |-> $past(raw_mode_i && frame_active_strobe_i))
    else $error("frame start without raw frame-active");
  a_encoder_by_write: assert property ($changed(encoder_check_enable_o) |-> wb_ack_o && $past(wb_we_i))
    else $error("encoder check changed without a write");
endmodule : misc_status_ctrl_checker

bind misc_status_ctrl misc_status_ctrl_checker #(.gpio_count(gpio_count)) misc_status_ctrl_checker_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .index_strap_i(index_strap_i), .mode_strap_i(mode_strap_i), .lock_detect_i(lock_detect_i),
  .parity_error_i(parity_error_i), .clock_error_i(clock_error_i), .control_error_i(control_error_i),
  .filter_wait_i(filter_wait_i), .raw_mode_i(raw_mode_i), .frame_active_strobe_i(frame_active_strobe_i),
  .gpio_output_mode_i(gpio_output_mode_i), .pulldown_enable_o(pulldown_enable_o),
  .receiver_lock_o(receiver_lock_o), .frame_start_o(frame_start_o),
  .encoder_check_enable_o(encoder_check_enable_o), .irq_o(irq_o));
`default_nettype wire

/* verif/misc_status_ctrl_bench.sv */
// Bench: register, lock monitor, framing and pull-down behaviour of the bank
`timescale 1ns/10ps
`default_nettype none
module misc_status_ctrl_bench;
  import misc_status_pkg::*;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        lock_detect_i, parity_error_i, clock_error_i, control_error_i, filter_wait_i;
  logic        raw_mode_i, frame_active_strobe_i, receiver_lock_o, frame_start_o;
  logic        encoder_check_enable_o, irq_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [2:0]  index_strap_i, mode_strap_i;
  logic [6:0]  gpio_output_mode_i, pulldown_enable_o;
  int          err_total = 0, n_compared = 0, cycles = 0, pulses;
  logic [7:0]  ra [6] = '{8'hb9, 8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hbe};
  logic [7:0]  rv [6] = '{8'h33, 8'h83, 8'h74, 8'h80, 8'h00, 8'h00};
  int          fl [5] = '{100, 140, 3, 12, 12};
  int          fe [5] = '{0, 1, 0, 1, 0};

  misc_status_ctrl #(.gpio_count(7)) misc_status_ctrl_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .index_strap_i(index_strap_i), .mode_strap_i(mode_strap_i), .lock_detect_i(lock_detect_i),
    .parity_error_i(parity_error_i), .clock_error_i(clock_error_i), .control_error_i(control_error_i),
    .filter_wait_i(filter_wait_i), .raw_mode_i(raw_mode_i), .frame_active_strobe_i(frame_active_strobe_i),
    .gpio_output_mode_i(gpio_output_mode_i), .pulldown_enable_o(pulldown_enable_o),
    .receiver_lock_o(receiver_lock_o), .frame_start_o(frame_start_o),
    .encoder_check_enable_o(encoder_check_enable_o), .irq_o(irq_o));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask : check

  task automatic wb_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b111;
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h00_0000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask : wb_write

  task automatic wb_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b110;
    wb_adr_i <= a;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    d = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb_read

  // One-cycle fault of the chosen kind, then sample just after the edge that sees it
  task automatic err_pulse(input int k);
    @(posedge clk_i);
    parity_error_i  <= (k == 0);
    clock_error_i   <= (k == 1);
    control_error_i <= (k == 2);
    @(posedge clk_i);
    {parity_error_i, clock_error_i, control_error_i} <= 3'b000;
    #1;
  endtask : err_pulse

  // A tail of a few cycles catches a registered pulse that lands after the strobe ends
  task automatic frame_run(input int len, input logic raw, output int n);
    n = 0;
    @(posedge clk_i);
    raw_mode_i            <= raw;
    frame_active_strobe_i <= 1'b1;
    repeat (len) begin
      @(posedge clk_i);
      if (frame_start_o === 1'b1) n++;
    end
    frame_active_strobe_i <= 1'b0;
    repeat (3) begin
      @(posedge clk_i);
      if (frame_start_o === 1'b1) n++;
    end
  endtask : frame_run

  task automatic end_test(input string name);
    $display("test done: %s", name);
  endtask : end_test

  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      finish_test();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'b1000;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    index_strap_i = 3'h5;
    mode_strap_i  = 3'h2;
    {lock_detect_i, parity_error_i, clock_error_i, control_error_i, filter_wait_i} = 5'b00000;
    {raw_mode_i, frame_active_strobe_i} = 2'b00;
    gpio_output_mode_i = 7'h00;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // Straps need a settle time before both done flags come up
    repeat (20) @(posedge clk_i);
    for (int i = 0; i < 6; i++) begin
      wb_read(ra[i], rd);
      check(rd, {24'h00_0000, rv[i]});
    end
    check(encoder_check_enable_o, 1'b0);
    check(pulldown_enable_o, 7'h7f);
    end_test("reset values");

    wb_read(8'hb8, rd);
    check(rd, 32'h0000_00da);
    // Only the strap-done event has happened so far
    wb_read(8'hc0, rd);
    check(rd, 32'h0000_0008);
    wb_write(8'hb8, 8'h00);
    wb_read(8'hb8, rd);
    check(rd, 32'h0000_00da);
    wb_read(8'ha0, rd);
    check(rd, 32'h0000_0000);
    end_test("strap status");

    wb_write(8'hba, 8'h03);
    #1 check(encoder_check_enable_o, 1'b1);
    wb_write(8'hbe, 8'hd5);
    wb_read(8'hbe, rd);
    check(rd, 32'h0000_0055);
    check(pulldown_enable_o, 7'h2a);
    gpio_output_mode_i <= 7'h0f;
    wb_write(8'hbe, 8'h00);
    #1 check(pulldown_enable_o, 7'h70);
    end_test("controls");

    wb_write(8'hb9, 8'h13);
    lock_detect_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1 check(receiver_lock_o, 1'b1);
    // Second round after relock shows the count started again from zero
    for (int i = 0; i < 6; i++) begin
      err_pulse(i % 3);
      check(receiver_lock_o, (i % 3 == 2) ? 0 : 1);
      if (i % 3 == 2) repeat (2) @(posedge clk_i);
    end
    wb_write(8'hc2, 8'h0f);
    wb_write(8'hc1, 8'h01);
    wb_write(8'hb9, 8'h03);
    err_pulse(1);
    check(receiver_lock_o, 1'b0);
    wb_read(8'hc0, rd);
    check(rd & 32'h0000_0001, 32'h0000_0001);
    #1 check(irq_o, 1'b1);
    wb_write(8'hc1, 8'h00);
    #1 check(irq_o, 1'b0);
    wb_write(8'hc2, 8'h01);
    wb_write(8'hc1, 8'h01);
    #1 check(irq_o, 1'b0);
    end_test("lock and interrupt");

    filter_wait_i <= 1'b1;
    wb_write(8'hb9, 8'h33);
    for (int i = 0; i < 3; i++) begin
      err_pulse(i);
      check(receiver_lock_o, 1'b1);
    end
    wb_write(8'hb9, 8'h03);
    err_pulse(0);
    check(receiver_lock_o, 1'b0);
    filter_wait_i <= 1'b0;
    end_test("filter wait");

    for (int i = 0; i < 5; i++) begin
      if (i == 2) wb_write(8'hbc, 8'h05);
      frame_run(fl[i], i != 4, pulses);
      check(pulses, fe[i]);
    end
    end_test("frame start");
    finish_test();
  end
endmodule : misc_status_ctrl_bench
`default_nettype wire
